/* File: rpc_pkg.sv */
`default_nettype none
package rpc_pkg;
	// ====================================================
	// register offsets
	localparam logic [9:0] OFS_SYNC_MATCH_SETUP = 10'h10f;
	localparam logic [9:0] OFS_PREAMBLE_QUALIFY_SETUP = 10'h111;
	localparam logic [9:0] OFS_PACKET_FORMAT_SELECT = 10'h13e;
	localparam logic [9:0] OFS_CARRIER_WORD_LOW = 10'h300;
	localparam logic [9:0] OFS_CARRIER_WORD_MID = 10'h301;
	localparam logic [9:0] OFS_CARRIER_WORD_HIGH = 10'h302;
	localparam logic [9:0] OFS_TRANSMIT_DEVIATION = 10'h304;
	localparam logic [9:0] OFS_DISCRIMINATOR_SETUP = 10'h305;
	localparam logic [9:0] OFS_MODULATION_SHAPING = 10'h306;
	localparam logic [9:0] OFS_POWER_READBACK = 10'h30c;
	localparam logic [9:0] OFS_QUALITY_READBACK = 10'h30d;
	localparam logic [9:0] OFS_BITRATE_HIGH = 10'h30e;
	localparam logic [9:0] OFS_BITRATE_LOW = 10'h30f;
	localparam logic [9:0] OFS_PROGRAM_RAM_PAGE_SELECT = 10'h313;
	localparam logic [9:0] OFS_TRANSMIT_BUFFER_BASE = 10'h314;
	// ====================================================
	// reset values
	localparam logic [7:0] RST_SYNC_MATCH_SETUP = 8'h18;
	localparam logic [7:0] RST_PREAMBLE_QUALIFY_SETUP = 8'h0b;
	localparam logic [7:0] RST_PACKET_FORMAT_SELECT = 8'h00;
	localparam logic [7:0] RST_CARRIER_WORD_LOW = 8'h80;
	localparam logic [7:0] RST_CARRIER_WORD_MID = 8'ha9;
	localparam logic [7:0] RST_CARRIER_WORD_HIGH = 8'h03;
	localparam logic [7:0] RST_TRANSMIT_DEVIATION = 8'h32;
	localparam logic [7:0] RST_DISCRIMINATOR_SETUP = 8'h06;
	localparam logic [7:0] RST_MODULATION_SHAPING = 8'h01;
	localparam logic [7:0] RST_READBACK = 8'h00;
	localparam logic [7:0] RST_BITRATE_HIGH = 8'h4e;
	localparam logic [7:0] RST_BITRATE_LOW = 8'h20;
	localparam logic [7:0] RST_PROGRAM_RAM_PAGE_SELECT = 8'h00;
	localparam logic [7:0] RST_TRANSMIT_BUFFER_BASE = 8'h80;
	// ====================================================
	// field positions and limits
	localparam int SYNC_TOL_LSB = 5;
	localparam int SYNC_LEN_MAX = 24;
	localparam int SKIP_SYNC_BIT = 6;
	localparam int AGC_LOCK_BIT = 5;
	localparam int SKIP_PREAMBLE_BIT = 4;
	localparam int PREAMBLE_PAIRS = 12;
	localparam int PREEMPH_BIT = 0;
	localparam int SHAPING_BIT = 1;
	localparam logic [7:0] DEVIATION_MASK = 8'h3f;
	localparam logic [7:0] DISCRIM_MASK = 8'h7f;
	localparam logic [7:0] SYNC_SETUP_MASK = 8'h7f;
	localparam logic [7:0] PREAMBLE_SETUP_MASK = 8'h7f;
	localparam logic [7:0] PRAM_PAGE_MASK = 8'h0f;
	localparam logic [7:0] SHAPING_SW_MASK = 8'h03;
	localparam int CARRIER_UNIT_KHZ = 10;
	localparam int DEVIATION_UNIT_KHZ = 10;
	localparam int BITRATE_UNIT_BPS = 100;

	typedef enum logic [2:0] {
		RPC_FMT_STD_PACKET,
		RPC_FMT_RESERVED1,
		RPC_FMT_STD_STREAM_RX,
		RPC_FMT_FSK_STREAM,
		RPC_FMT_FSK_PACKET
	} rpc_format_t;

	// settings handed to the radio controller
	typedef struct packed {
		logic [1:0] sync_tolerance;
		logic [4:0] sync_bits;
		logic sync_detect_on;
		logic skip_sync_stream;
		logic agc_lock_enable;
		logic skip_preamble;
		logic [3:0] preamble_errors_allowed;
		logic preamble_qualify_on;
		logic [7:0] packet_format_code;
		logic format_valid;
		logic [23:0] carrier_word;
		logic [5:0] deviation_steps;
		logic [6:0] demod_bandwidth_code;
		logic gauss_shaping;
		logic preemphasis_on;
		logic [15:0] bitrate_word;
		logic [3:0] pram_page;
		logic [7:0] tx_buffer_base;
	} rpc_config_t;
endpackage
`default_nettype wire

/* File: rpc_regs.sv */
`timescale 1ns/10ps
`default_nettype none
// What this block does
// [RULE1] sync tolerance field allows zero to three bit mismatches; four to seven reserved.
// [RULE2] sync length compares 0 to 24 bits, default 24; zero disables detection.
// [RULE3] sync-skip bit makes streaming receive bypass sync word detection.
// [RULE4] gain-lock bit freezes gain after preamble, FSK packet and streaming only.
// [RULE5] preamble-skip bit omits preamble detection and qualification, searching sync only.
// [RULE6] preamble level tolerates twelve minus value bad pairs; zero disables qualification.
// [RULE7] format byte: 0 standard packet, 2 standard rx stream, 3 FSK stream, 4 FSK packet.
// [RULE8] carrier word is 24 bits over three bytes, low first, in 10 kHz units.
// [RULE9] transmit deviation is six-bit field times 10 kHz, reset 50.
// [RULE10] software keeps deviation 50 for standard mode, smaller for slow FSK.
// [RULE11] seven-bit discriminator code equals 3.25 MHz over deviation plus error; reset 6.
// [RULE12] modulation register upper six bits are driven by the radio controller.
// [RULE13] preemphasis bit enables transmit preemphasis filter; resets to one.
// [RULE14] software keeps preemphasis on above 250 kbps and in standard mode.
// [RULE15] power readback is read-only signed dBm value.
// [RULE16] quality readback is read-only signal quality value.
// [RULE17] bit rate is (256 times high byte plus low byte) times 100 bps.
// [RULE18] transmit buffer base gives packet RAM start address; resets to 128.
// [RULE19] software writes reserved bits at default and avoids reserved encodings.
// [RULE20] writes to readback registers are ignored; receive logic updates them.
module rpc_regs
	import rpc_pkg::*;
(
	input wire logic clk_i, // 25 MHz clock
	input wire logic reset_i, // synchronous reset, active high
	input wire logic [9:0] addr_i, // register address
	input wire logic wr_en_i, // one-cycle write strobe
	input wire logic rd_en_i, // one-cycle read strobe
	input wire logic [7:0] wr_data_i, // write data
	output logic [7:0] rd_data_o, // read data, valid cycle after rd_en_i
	output logic rd_valid_o, // read data valid pulse
	output logic addr_err_o, // access hit an unmapped address, pulse
	input wire logic meas_valid_i, // receive logic has a new measurement
	input wire logic [7:0] meas_power_i, // signed received power, dBm
	input wire logic [7:0] meas_quality_i, // signal quality indicator
	input wire logic ctrl_wr_i, // radio controller writes its own bits
	input wire logic [5:0] ctrl_bits_i, // controller owned modulation bits
	output rpc_config_t cfg_o // decoded settings to the controller
);
	// ====================================================
	// register state
	logic [7:0] sync_match_setup, next_sync_match_setup;
	logic [7:0] preamble_qualify_setup, next_preamble_qualify_setup;
	logic [7:0] packet_format_select, next_packet_format_select;
	logic [7:0] carrier_word_low, next_carrier_word_low;
	logic [7:0] carrier_word_mid, next_carrier_word_mid;
	logic [7:0] carrier_word_high, next_carrier_word_high;
	logic [7:0] transmit_deviation, next_transmit_deviation;
	logic [7:0] discriminator_setup, next_discriminator_setup;
	logic [7:0] modulation_shaping, next_modulation_shaping;
	logic [7:0] power_readback, next_power_readback;
	logic [7:0] quality_readback, next_quality_readback;
	logic [7:0] bitrate_high, next_bitrate_high;
	logic [7:0] bitrate_low, next_bitrate_low;
	logic [7:0] program_ram_page_select, next_program_ram_page_select;
	logic [7:0] transmit_buffer_base, next_transmit_buffer_base;
	logic [7:0] next_rd_data;
	logic next_rd_valid, next_addr_err, hit;
	rpc_config_t next_cfg;

	function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wd,
		input logic [7:0] mask);
		merge = (old & ~mask) | (wd & mask);
	endfunction

	// ====================================================
	// write path
	always_comb begin
		next_sync_match_setup = sync_match_setup;
		next_preamble_qualify_setup = preamble_qualify_setup;
		next_packet_format_select = packet_format_select;
		next_carrier_word_low = carrier_word_low;
		next_carrier_word_mid = carrier_word_mid;
		next_carrier_word_high = carrier_word_high;
		next_transmit_deviation = transmit_deviation;
		next_discriminator_setup = discriminator_setup;
		next_modulation_shaping = modulation_shaping;
		next_bitrate_high = bitrate_high;
		next_bitrate_low = bitrate_low;
		next_program_ram_page_select = program_ram_page_select;
		next_transmit_buffer_base = transmit_buffer_base;
		next_power_readback = power_readback;
		next_quality_readback = quality_readback;
		// reserved bits are held at zero whatever software writes
		if (wr_en_i) begin
			if (addr_i == OFS_SYNC_MATCH_SETUP) begin
				next_sync_match_setup = wr_data_i & SYNC_SETUP_MASK; // RULE1 RULE2
			end else if (addr_i == OFS_PREAMBLE_QUALIFY_SETUP) begin
				next_preamble_qualify_setup = wr_data_i & PREAMBLE_SETUP_MASK;
			end else if (addr_i == OFS_PACKET_FORMAT_SELECT) begin
				next_packet_format_select = wr_data_i; // RULE7
			end else if (addr_i == OFS_CARRIER_WORD_LOW) begin
				next_carrier_word_low = wr_data_i; // RULE8
			end else if (addr_i == OFS_CARRIER_WORD_MID) begin
				next_carrier_word_mid = wr_data_i; // RULE8
			end else if (addr_i == OFS_CARRIER_WORD_HIGH) begin
				next_carrier_word_high = wr_data_i; // RULE8
			end else if (addr_i == OFS_TRANSMIT_DEVIATION) begin
				next_transmit_deviation = wr_data_i & DEVIATION_MASK; // RULE9
			end else if (addr_i == OFS_DISCRIMINATOR_SETUP) begin
				next_discriminator_setup = wr_data_i & DISCRIM_MASK; // RULE11
			end else if (addr_i == OFS_MODULATION_SHAPING) begin
				// software reaches only the two shaping bits
				next_modulation_shaping = merge(modulation_shaping, wr_data_i,
					SHAPING_SW_MASK); // RULE12 RULE13
			end else if (addr_i == OFS_BITRATE_HIGH) begin
				next_bitrate_high = wr_data_i; // RULE17
			end else if (addr_i == OFS_BITRATE_LOW) begin
				next_bitrate_low = wr_data_i; // RULE17
			end else if (addr_i == OFS_PROGRAM_RAM_PAGE_SELECT) begin
				next_program_ram_page_select = wr_data_i & PRAM_PAGE_MASK;
			end else if (addr_i == OFS_TRANSMIT_BUFFER_BASE) begin
				next_transmit_buffer_base = wr_data_i; // RULE18
			end
		end
		// controller write applied after software so the owner wins on a clash
		if (ctrl_wr_i) begin
			next_modulation_shaping = merge(next_modulation_shaping, {ctrl_bits_i, 2'b00},
				~SHAPING_SW_MASK); // RULE12
		end
		// readback is only ever loaded from the measurement, never from the port
		if (meas_valid_i) begin
			next_power_readback = meas_power_i; // RULE15 RULE20
			next_quality_readback = meas_quality_i; // RULE16 RULE20
		end
	end

	// ====================================================
	// read path
	always_comb begin
		next_rd_data = 8'h00;
		hit = 1'b1;
		if (addr_i == OFS_SYNC_MATCH_SETUP) begin
			next_rd_data = sync_match_setup;
		end else if (addr_i == OFS_PREAMBLE_QUALIFY_SETUP) begin
			next_rd_data = preamble_qualify_setup;
		end else if (addr_i == OFS_PACKET_FORMAT_SELECT) begin
			next_rd_data = packet_format_select;
		end else if (addr_i == OFS_CARRIER_WORD_LOW) begin
			next_rd_data = carrier_word_low;
		end else if (addr_i == OFS_CARRIER_WORD_MID) begin
			next_rd_data = carrier_word_mid;
		end else if (addr_i == OFS_CARRIER_WORD_HIGH) begin
			next_rd_data = carrier_word_high;
		end else if (addr_i == OFS_TRANSMIT_DEVIATION) begin
			next_rd_data = transmit_deviation;
		end else if (addr_i == OFS_DISCRIMINATOR_SETUP) begin
			next_rd_data = discriminator_setup;
		end else if (addr_i == OFS_MODULATION_SHAPING) begin
			next_rd_data = modulation_shaping;
		end else if (addr_i == OFS_POWER_READBACK) begin
			next_rd_data = power_readback; // RULE15
		end else if (addr_i == OFS_QUALITY_READBACK) begin
			next_rd_data = quality_readback; // RULE16
		end else if (addr_i == OFS_BITRATE_HIGH) begin
			next_rd_data = bitrate_high;
		end else if (addr_i == OFS_BITRATE_LOW) begin
			next_rd_data = bitrate_low;
		end else if (addr_i == OFS_PROGRAM_RAM_PAGE_SELECT) begin
			next_rd_data = program_ram_page_select;
		end else if (addr_i == OFS_TRANSMIT_BUFFER_BASE) begin
			next_rd_data = transmit_buffer_base;
		end else begin
			hit = 1'b0;
		end
		next_rd_valid = rd_en_i;
		next_addr_err = (rd_en_i | wr_en_i) & ~hit;
		if (!rd_en_i) begin
			next_rd_data = rd_data_o;
		end
	end

	// ====================================================
	// decoded settings
	always_comb begin
		next_cfg.sync_tolerance = sync_match_setup[SYNC_TOL_LSB +: 2]; // RULE1
		// reserved lengths above 24 are clipped to the full word
		next_cfg.sync_bits = (sync_match_setup[4:0] > 5'(SYNC_LEN_MAX)) ?
			5'(SYNC_LEN_MAX) : sync_match_setup[4:0]; // RULE2
		next_cfg.sync_detect_on = (sync_match_setup[4:0] != 5'h0); // RULE2
		next_cfg.skip_sync_stream = preamble_qualify_setup[SKIP_SYNC_BIT] &
			(packet_format_select == 8'(RPC_FMT_FSK_STREAM) |
			packet_format_select == 8'(RPC_FMT_STD_STREAM_RX)); // RULE3
		next_cfg.agc_lock_enable = preamble_qualify_setup[AGC_LOCK_BIT] &
			(packet_format_select == 8'(RPC_FMT_FSK_STREAM) |
			packet_format_select == 8'(RPC_FMT_FSK_PACKET)); // RULE4
		next_cfg.skip_preamble = preamble_qualify_setup[SKIP_PREAMBLE_BIT]; // RULE5
		next_cfg.preamble_qualify_on = ~preamble_qualify_setup[SKIP_PREAMBLE_BIT] &
			(preamble_qualify_setup[3:0] != 4'h0); // RULE6
		next_cfg.preamble_errors_allowed = (preamble_qualify_setup[3:0] > 4'(PREAMBLE_PAIRS)) ?
			4'h0 : 4'(PREAMBLE_PAIRS) - preamble_qualify_setup[3:0]; // RULE6
		next_cfg.packet_format_code = packet_format_select; // RULE7
		next_cfg.format_valid = (packet_format_select <= 8'(RPC_FMT_FSK_PACKET)) &
			(packet_format_select != 8'(RPC_FMT_RESERVED1)); // RULE7
		next_cfg.carrier_word = {carrier_word_high, carrier_word_mid,
			carrier_word_low}; // RULE8
		next_cfg.deviation_steps = transmit_deviation[5:0]; // RULE9
		next_cfg.demod_bandwidth_code = discriminator_setup[6:0]; // RULE11
		next_cfg.gauss_shaping = modulation_shaping[SHAPING_BIT];
		next_cfg.preemphasis_on = modulation_shaping[PREEMPH_BIT]; // RULE13
		next_cfg.bitrate_word = {bitrate_high, bitrate_low}; // RULE17
		next_cfg.pram_page = program_ram_page_select[3:0];
		next_cfg.tx_buffer_base = transmit_buffer_base; // RULE18
	end

	// ====================================================
	// registers
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			sync_match_setup <= RST_SYNC_MATCH_SETUP;
			preamble_qualify_setup <= RST_PREAMBLE_QUALIFY_SETUP;
			packet_format_select <= RST_PACKET_FORMAT_SELECT;
			carrier_word_low <= RST_CARRIER_WORD_LOW;
			carrier_word_mid <= RST_CARRIER_WORD_MID;
			carrier_word_high <= RST_CARRIER_WORD_HIGH;
			transmit_deviation <= RST_TRANSMIT_DEVIATION; // RULE9
			discriminator_setup <= RST_DISCRIMINATOR_SETUP; // RULE11
			modulation_shaping <= RST_MODULATION_SHAPING; // RULE13
			power_readback <= RST_READBACK;
			quality_readback <= RST_READBACK;
			bitrate_high <= RST_BITRATE_HIGH;
			bitrate_low <= RST_BITRATE_LOW;
			program_ram_page_select <= RST_PROGRAM_RAM_PAGE_SELECT;
			transmit_buffer_base <= RST_TRANSMIT_BUFFER_BASE; // RULE18
			rd_data_o <= 8'h00;
			rd_valid_o <= 1'b0;
			addr_err_o <= 1'b0;
			cfg_o <= '0;
		end else begin
			sync_match_setup <= next_sync_match_setup;
			preamble_qualify_setup <= next_preamble_qualify_setup;
			packet_format_select <= next_packet_format_select;
			carrier_word_low <= next_carrier_word_low;
			carrier_word_mid <= next_carrier_word_mid;
			carrier_word_high <= next_carrier_word_high;
			transmit_deviation <= next_transmit_deviation;
			discriminator_setup <= next_discriminator_setup;
			modulation_shaping <= next_modulation_shaping;
			power_readback <= next_power_readback;
			quality_readback <= next_quality_readback;
			bitrate_high <= next_bitrate_high;
			bitrate_low <= next_bitrate_low;
			program_ram_page_select <= next_program_ram_page_select;
			transmit_buffer_base <= next_transmit_buffer_base;
			rd_data_o <= next_rd_data;
			rd_valid_o <= next_rd_valid;
			addr_err_o <= next_addr_err;
			cfg_o <= next_cfg;
		end
	end
endmodule
`default_nettype wire

/* File: rpc_regs_chk.sv */
`timescale 1ns/10ps
`default_nettype none
module rpc_regs_chk
	import rpc_pkg::*;
(
	input wire logic clk_i, // clock
	input wire logic reset_i, // sync reset
	input wire logic [9:0] addr_i, // address
	input wire logic wr_en_i, // write strobe
	input wire logic rd_en_i, // read strobe
	input wire logic [7:0] wr_data_i, // write data
	input wire logic [7:0] rd_data_o, // read data
	input wire logic rd_valid_o, // read valid
	input wire logic addr_err_o, // address error
	input wire logic meas_valid_i, // new measurement
	input wire logic [7:0] meas_power_i, // power
	input wire logic [7:0] meas_quality_i, // quality
	input wire logic ctrl_wr_i, // controller write
	input wire logic [5:0] ctrl_bits_i, // controller bits
	input wire rpc_config_t cfg_o // decoded settings
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	logic mapped;
	assign mapped = addr_i inside {10'h10f, 10'h111, 10'h13e, 10'h300, 10'h301, 10'h302,
		10'h304, 10'h305, 10'h306, 10'h30c, 10'h30d, 10'h30e, 10'h30f, 10'h313, 10'h314};
	// ====================================================
	// readback and controller load, read two cycles later
	sequence s_meas;
		meas_valid_i ##1 !meas_valid_i ##1 (rd_en_i && addr_i == OFS_POWER_READBACK);
	endsequence
	sequence s_ctrl;
		ctrl_wr_i ##1 !ctrl_wr_i ##1 (rd_en_i && addr_i == OFS_MODULATION_SHAPING);
	endsequence
	// ====================================================
	// assertions
	a_read_valid: assert property (rd_en_i |=> rd_valid_o)
		else $error("read valid missing");
	a_valid_cause: assert property (rd_valid_o |-> $past(rd_en_i))
		else $error("read valid without read");
	a_unmapped_err: assert property ((rd_en_i || wr_en_i) && !mapped |=> addr_err_o)
		else $error("unmapped access not flagged");
	a_err_cause: assert property (addr_err_o |-> $past((rd_en_i || wr_en_i) && !mapped))
		else $error("address error without cause");
	a_unmapped_zero: assert property (rd_en_i && !mapped |=> rd_data_o == 8'h00)
		else $error("unmapped read not zero");
	a_data_hold: assert property (!rd_en_i |=> $stable(rd_data_o))
		else $error("read data changed without read");
	a_power_load: assert property (s_meas |=> rd_data_o == $past(meas_power_i, 3))
		else $error("power readback not loaded");
	a_ctrl_bits: assert property (s_ctrl |=> rd_data_o[7:2] == $past(ctrl_bits_i, 3))
		else $error("controller bits not loaded");
	a_dev_cfg: assert property (wr_en_i && addr_i == OFS_TRANSMIT_DEVIATION
		|-> ##2 cfg_o.deviation_steps == $past(wr_data_i[5:0], 2))
		else $error("deviation setting wrong");
	a_carrier_cfg: assert property (wr_en_i && addr_i == OFS_CARRIER_WORD_LOW
		|-> ##2 cfg_o.carrier_word[7:0] == $past(wr_data_i, 2))
		else $error("carrier low byte wrong");
	a_preemph_cfg: assert property (wr_en_i && addr_i == OFS_MODULATION_SHAPING
		|-> ##2 cfg_o.preemphasis_on == $past(wr_data_i[0], 2))
		else $error("preemphasis setting wrong");
endmodule
bind rpc_regs rpc_regs_chk rpc_regs_chk_inst (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i),
	.wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .wr_data_i(wr_data_i), .rd_data_o(rd_data_o),
	.rd_valid_o(rd_valid_o), .addr_err_o(addr_err_o), .meas_valid_i(meas_valid_i),
	.meas_power_i(meas_power_i), .meas_quality_i(meas_quality_i), .ctrl_wr_i(ctrl_wr_i),
	.ctrl_bits_i(ctrl_bits_i), .cfg_o(cfg_o));
`default_nettype wire

/* File: test_radio_packet_config_regs.sv */
`timescale 1ns/10ps
`default_nettype none
module test_radio_packet_config_regs
	import rpc_pkg::*;
;
	// ====================================================
	// stimulus, tables and design
	logic clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic [9:0] addr_i = 10'h000;
	logic wr_en_i = 1'b0;
	logic rd_en_i = 1'b0;
	logic [7:0] wr_data_i = 8'h00;
	logic meas_valid_i = 1'b0;
	logic [7:0] meas_power_i = 8'h00;
	logic [7:0] meas_quality_i = 8'h00;
	logic ctrl_wr_i = 1'b0;
	logic [5:0] ctrl_bits_i = 6'h00;
	logic [7:0] rd_data_o;
	logic rd_valid_o;
	logic addr_err_o;
	rpc_config_t cfg_o;
	int n_fail = 0;
	int checks_done = 0;
	int seed = 32'h55ee_76ac;
	logic [7:0] shadow [15];
	localparam logic [9:0] OFS [15] = '{10'h10f, 10'h111, 10'h13e, 10'h300, 10'h301, 10'h302,
		10'h304, 10'h305, 10'h306, 10'h30c, 10'h30d, 10'h30e, 10'h30f, 10'h313, 10'h314};
	localparam logic [7:0] RST [15] = '{8'h18, 8'h0b, 8'h00, 8'h80, 8'ha9, 8'h03, 8'h32,
		8'h06, 8'h01, 8'h00, 8'h00, 8'h4e, 8'h20, 8'h00, 8'h80};
	// software writable bits; readbacks take none, modulation keeps its controller bits
	localparam logic [7:0] MSK [15] = '{8'h7f, 8'h7f, 8'hff, 8'hff, 8'hff, 8'hff, 8'h3f,
		8'h7f, 8'h03, 8'h00, 8'h00, 8'hff, 8'hff, 8'h0f, 8'hff};
	rpc_regs rpc_regs_inst (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i),
		.wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .wr_data_i(wr_data_i), .rd_data_o(rd_data_o),
		.rd_valid_o(rd_valid_o), .addr_err_o(addr_err_o), .meas_valid_i(meas_valid_i),
		.meas_power_i(meas_power_i), .meas_quality_i(meas_quality_i), .ctrl_wr_i(ctrl_wr_i),
		.ctrl_bits_i(ctrl_bits_i), .cfg_o(cfg_o));
	initial begin
		forever #20 clk_i = ~clk_i;
	end
	// ====================================================
	// tasks and expectations
	function automatic logic [7:0] merge(input int idx, input logic [7:0] d);
		return (shadow[idx] & ~MSK[idx]) | (d & MSK[idx]);
	endfunction
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic check_val(input logic [23:0] got, input logic [23:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic check_flag(input logic got, input logic exp);
		check_val({23'h0, got}, {23'h0, exp});
	endtask
	// inputs always move 1 ns after the edge so no race with the design's sampling
	task automatic cycle_on();
		@(posedge clk_i);
		#1;
	endtask
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		cycle_on();
		addr_i = a;
		wr_data_i = d;
		wr_en_i = 1'b1;
		cycle_on();
		wr_en_i = 1'b0;
	endtask
	task automatic rd(input logic [9:0] a, input logic [7:0] exp, input logic err);
		cycle_on();
		addr_i = a;
		rd_en_i = 1'b1;
		cycle_on();
		rd_en_i = 1'b0;
		check_flag(rd_valid_o, 1'b1);
		check_flag(addr_err_o, err);
		check_val(24'(rd_data_o), 24'(exp));
	endtask
	initial begin
		#4000000;
		n_fail++;
		final_report();
	end
	// ====================================================
	// main sequence
	initial begin
		int idx;
		logic [7:0] d;
		repeat (5) @(posedge clk_i);
		#1;
		reset_i = 1'b0;
		for (int i = 0; i < 15; i++) begin
			shadow[i] = RST[i];
			rd(OFS[i], RST[i], 1'b0);
		end
		check_val(cfg_o.carrier_word, 24'h03_a980);
		check_val(24'(cfg_o.bitrate_word), 24'h00_4e20);
		cycle_on();
		meas_valid_i = 1'b1;
		meas_power_i = 8'($random(seed));
		meas_quality_i = 8'($random(seed));
		cycle_on();
		meas_valid_i = 1'b0;
		shadow[9] = meas_power_i;
		shadow[10] = meas_quality_i;
		rd(OFS[9], shadow[9], 1'b0);
		rd(OFS[10], shadow[10], 1'b0);
		// controller and software hit the modulation register in the same cycle
		cycle_on();
		ctrl_bits_i = 6'h2d;
		ctrl_wr_i = 1'b1;
		addr_i = OFS[8];
		wr_data_i = 8'hfe;
		wr_en_i = 1'b1;
		cycle_on();
		ctrl_wr_i = 1'b0;
		wr_en_i = 1'b0;
		shadow[8] = 8'hb6;
		rd(OFS[8], shadow[8], 1'b0);
		check_flag(cfg_o.preemphasis_on, 1'b0);
		check_flag(cfg_o.gauss_shaping, 1'b1);
		for (int n = 0; n < 200; n++) begin
			idx = $unsigned($random(seed)) % 15;
			d = 8'($random(seed));
			wr(OFS[idx], d);
			shadow[idx] = merge(idx, d);
			rd(OFS[idx], shadow[idx], 1'b0);
		end
		check_val(cfg_o.carrier_word, {shadow[5], shadow[4], shadow[3]});
		check_val(24'(cfg_o.bitrate_word), 24'({shadow[11], shadow[12]}));
		check_val(24'(cfg_o.deviation_steps), 24'(shadow[6][5:0]));
		check_val(24'(cfg_o.demod_bandwidth_code), 24'(shadow[7][6:0]));
		check_val(24'(cfg_o.tx_buffer_base), 24'(shadow[14]));
		check_val(24'(cfg_o.sync_tolerance), 24'(shadow[0][6:5]));
		check_val(24'(cfg_o.pram_page), 24'(shadow[13][3:0]));
		for (int v = 0; v < 32; v++) begin
			wr(OFS[0], 8'(v));
			cycle_on();
			check_val(24'(cfg_o.sync_bits), 24'((v > 24) ? 24 : v));
			check_flag(cfg_o.sync_detect_on, v != 0);
		end
		for (int v = 0; v < 16; v++) begin
			wr(OFS[1], 8'(v));
			cycle_on();
			check_flag(cfg_o.preamble_qualify_on, v != 0);
			if (v != 0) check_val(24'(cfg_o.preamble_errors_allowed), 24'((v > 12) ? 0 : 12 - v));
		end
		wr(OFS[1], 8'h7b);
		for (int v = 0; v < 8; v++) begin
			wr(OFS[2], 8'(v));
			cycle_on();
			check_val(24'(cfg_o.packet_format_code), 24'(v));
			check_flag(cfg_o.format_valid, v inside {0, 2, 3, 4});
			check_flag(cfg_o.skip_sync_stream, v inside {2, 3});
			check_flag(cfg_o.agc_lock_enable, v inside {3, 4});
			check_flag(cfg_o.skip_preamble, 1'b1);
			check_flag(cfg_o.preamble_qualify_on, 1'b0);
		end
		wr(OFS[2], 8'h03);
		wr(OFS[1], 8'h0b);
		cycle_on();
		check_flag(cfg_o.skip_sync_stream, 1'b0);
		check_flag(cfg_o.agc_lock_enable, 1'b0);
		check_flag(cfg_o.skip_preamble, 1'b0);
		rd(10'h200, 8'h00, 1'b1);
		wr(10'h303, 8'h5a);
		check_flag(addr_err_o, 1'b1);
		rd(OFS[6], shadow[6], 1'b0);
		// software keeps the standard mode defaults for deviation and preemphasis
		wr(OFS[2], 8'h00);
		wr(OFS[6], 8'h32);
		wr(OFS[8], 8'h01);
		cycle_on();
		check_val(24'(cfg_o.deviation_steps), 24'h00_0032);
		check_flag(cfg_o.preemphasis_on, 1'b1);
		// a second reset must bring back every default, readbacks included
		cycle_on();
		reset_i = 1'b1;
		repeat (5) cycle_on();
		reset_i = 1'b0;
		for (int i = 0; i < 15; i++) begin
			rd(OFS[i], RST[i], 1'b0);
		end
		check_val(cfg_o.carrier_word, 24'h03_a980);
		final_report();
	end
endmodule
`default_nettype wire
